/* dv/sdfc_channel_test.sv */
// Self-checking testbench for one sigma-delta filter channel.
module sdfc_channel_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Signals, stimulus table and instances
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ctrl;
		logic [19:0] ratio;
		logic [31:0] thresh;
		logic [1:0] pat;
		logic [31:0] dexp;
		logic [1:0] fexp;
	} sdfc_row_t;
	localparam logic [31:0] TH0 = 32'hffff0000;

	logic clk, rst_n, wr, rd, mclk, mbit, data_ready_pin, cmp_irq;
	logic [1:0] pat, hold;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, d, f;
	int fails, checked;
	sdfc_row_t rows [15];
	logic [7:0] ra [5];
	logic [31:0] rv [5];

	sdfc_channel DUT (.clk(clk), .rst_n(rst_n), .modulator_clock_input(mclk),
		.modulator_bit_input(mbit), .hold_strobe_input(hold), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .data_ready_pin(data_ready_pin), .cmp_irq(cmp_irq));
	sdfc_mod_src src (.run(1'b1), .pattern(pat), .mod_clk(mclk), .mod_bit(mbit));

	// Free-running 40 MHz clock.
	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict

	// Signed range compare, so noisy sampling phases can be given a tolerance.
	task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		checked++;
		if ($isunknown(got) || $signed(got) < $signed(lo) || $signed(got) > $signed(hi)) begin
			$display("unexpected at %0t: got %h, expected %h", $time, got, lo);
			fails++;
		end
	endtask : chk_rng

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		chk_rng(got, exp, exp);
	endtask : chk

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe, so they are taken just then.
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd_reg

	task automatic wait_rdy();
		int n;
		n = 0;
		while (data_ready_pin !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 5000) begin
				$display("unexpected at %0t: got %h, expected %h", $time, 1'b0, 1'b1);
				fails++;
				print_verdict();
			end
		end
	endtask : wait_rdy

	// The first words after a change are warm-up, so only the fifth one is kept.
	task automatic get_word(output logic [31:0] v);
		repeat (5) begin
			wait_rdy();
			rd_reg(sdfc_pkg::ADDR_DATA, v);
			repeat (2) @(posedge clk);
			#1;
		end
	endtask : get_word

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		hold = 2'h0;
		pat = 2'h1;
		fails = 0;
		checked = 0;
		rows = '{'{8'h01, 20'h00007, TH0, 2'h1, 32'h8, 2'h0},
			'{8'h03, 20'h00007, TH0, 2'h0, 32'hffffffc0, 2'h0},
			'{8'h05, 20'h000ff, TH0, 2'h1, 32'h01000000, 2'h0},
			'{8'h07, 20'h0000f, TH0, 2'h0, 32'hfffffe00, 2'h0},
			'{8'h01, 20'h00001, TH0, 2'h2, 32'h0, 2'h0},
			'{8'h21, 20'h04003, TH0, 2'h1, 32'hc, 2'h0},
			'{8'h21, 20'hfe000, TH0, 2'h0, 32'hffffff80, 2'h0},
			'{8'h01, 20'h01f00, 32'h001f0000, 2'h1, 32'h1, 2'h1},
			'{8'h01, 20'h01f00, 32'h00200000, 2'h1, 32'h1, 2'h0},
			'{8'h11, 20'h01f00, 32'h7fff0000, 2'h1, 32'h1, 2'h1},
			'{8'h11, 20'h01f00, 32'h80000000, 2'h1, 32'h1, 2'h0},
			'{8'h09, 20'h01f00, 32'h03ff0000, 2'h1, 32'h1, 2'h1},
			'{8'h19, 20'h01f00, 32'hffff0801, 2'h1, 32'h1, 2'h2},
			'{8'h01, 20'h01f00, 32'hffff0001, 2'h0, 32'hffffffff, 2'h2},
			'{8'h01, 20'h01f00, TH0, 2'h0, 32'hffffffff, 2'h0}};
		ra = '{sdfc_pkg::ADDR_CTRL, sdfc_pkg::ADDR_RATIO, sdfc_pkg::ADDR_THRESH, 8'h14,
			sdfc_pkg::ADDR_FLAGS};
		rv = '{{24'h0, sdfc_pkg::CTRL_RST}, {12'h0, sdfc_pkg::RATIO_RST}, sdfc_pkg::THRESH_RST,
			32'h0, 32'h0};
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		// Each row: configure, let the filters settle, check one word and the flags.
		foreach (rows[i]) begin
			wr_reg(sdfc_pkg::ADDR_CTRL, 32'h0);
			wr_reg(sdfc_pkg::ADDR_THRESH, rows[i].thresh);
			wr_reg(sdfc_pkg::ADDR_RATIO, {12'h000, rows[i].ratio});
			pat <= rows[i].pat;
			wr_reg(sdfc_pkg::ADDR_CTRL, {24'h0, rows[i].ctrl});
			repeat (1200) @(posedge clk);
			rd_reg(sdfc_pkg::ADDR_FLAGS, f);
			get_word(d);
			chk(d, rows[i].dexp);
			repeat (300) @(posedge clk);
			#1;
			chk({31'h0, cmp_irq}, {31'h0, |rows[i].fexp});
			rd_reg(sdfc_pkg::ADDR_FLAGS, f);
			chk({30'h0, f[2:1]}, {30'h0, rows[i].fexp});
		end
		// Reset in mid-run clears the outputs and the registers.
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk({30'h0, data_ready_pin, cmp_irq}, 32'h0);
		@(posedge clk);
		rst_n <= 1'b1;
		wr_reg(sdfc_pkg::ADDR_FLAGS, 32'hffffffff);
		foreach (ra[i]) begin
			rd_reg(ra[i], d);
			chk(d, rv[i]);
		end
		@(posedge clk);
		#1;
		chk(rdata, 32'h0);
		// Hold mode: the unselected strobe is ignored, the selected one delivers the sum.
		wr_reg(sdfc_pkg::ADDR_RATIO, 32'h0);
		pat <= 2'h1;
		wr_reg(sdfc_pkg::ADDR_CTRL, 32'he1);
		@(posedge clk);
		hold <= 2'h1;
		repeat (4) @(posedge clk);
		hold <= 2'h0;
		repeat (60) @(posedge clk);
		#1;
		chk({31'h0, data_ready_pin}, 32'h0);
		@(posedge clk);
		hold <= 2'h2;
		repeat (4) @(posedge clk);
		hold <= 2'h0;
		repeat (300) @(posedge clk);
		#1;
		chk({31'h0, data_ready_pin}, 32'h1);
		rd_reg(sdfc_pkg::ADDR_DATA, d);
		repeat (14) @(posedge clk);
		hold <= 2'h2;
		wait_rdy();
		rd_reg(sdfc_pkg::ADDR_DATA, d);
		@(posedge clk);
		hold <= 2'h0;
		chk_rng(d, 32'd39, 32'd41);
		repeat (2) @(posedge clk);
		#1;
		chk({31'h0, data_ready_pin}, 32'h0);
		// Select the first strobe instead; the second one must now be ignored.
		wr_reg(sdfc_pkg::ADDR_CTRL, 32'h61);
		hold <= 2'h2;
		repeat (8) @(posedge clk);
		hold <= 2'h0;
		repeat (8) @(posedge clk);
		#1;
		chk({31'h0, data_ready_pin}, 32'h0);
		@(posedge clk);
		hold <= 2'h1;
		repeat (8) @(posedge clk);
		hold <= 2'h0;
		#1;
		chk({31'h0, data_ready_pin}, 32'h1);
		print_verdict();
	end
endmodule : sdfc_channel_test

/* dv/sdfc_mod_src.sv */
// Behavioural delta-sigma modulator driving the channel's bit and bit-clock inputs.
module sdfc_mod_src (
	input wire logic run,
	input wire logic [1:0] pattern,
	output logic mod_clk,
	output logic mod_bit
);
	timeunit 1ns;
	timeprecision 1ps;

	logic toggle;

	// The bit changes on the falling edge, so it is stable for a whole half period after
	// each rise. The odd start offset keeps the bit clock unrelated in phase to clk.
	// Pattern 0 is all zeros, 1 all ones and 2 alternates.
	initial begin
		mod_clk = 1'b0;
		mod_bit = 1'b0;
		toggle = 1'b0;
		#37;
		forever begin
			#100;
			mod_clk = run;
			#100;
			mod_clk = 1'b0;
			toggle = ~toggle;
			mod_bit = (pattern == 2'h2) ? toggle : pattern[0];
		end
	end
endmodule : sdfc_mod_src

/* hdl/sdfc_channel.sv */
// One channel of a delta-sigma decimation filter: comparator, sinc filter and integrator.
// Function
// - Comparator ratio programmable from 1 to 32.
// - Comparator result checked against high and low thresholds.
// - Threshold hits raise interrupt and record condition.
// - Comparator result never readable by the host.
// - Comparator maps bits to zero and one.
// - Comparator result up to 32768, unsigned.
// - Sinc structure selectable, ratio 1 to 256.
// - Sinc filter maps bits to minus/plus one.
// - One sinc word per ratio count of samples.
// - Sinc output signed, reaches 16777216 in magnitude.
// - Enabled sinc filter runs continuously.
// - Data-ready pin raised, dropped after data read.
// - Integrator is 32-bit signed accumulator.
// - Mode bit picks hold strobe or count.
// - Disabled integrator cleared and bypassed.
// - Hold strobe rising edge stores and clears.
// - Oversampling mode sums 1 to 128 words.
// - Integrator range reaches ratio cubed times count.
// - Overflow sets flag, clears accumulator, continues.
module sdfc_channel (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic modulator_clock_input,
	input wire logic modulator_bit_input,
	input wire logic [1:0] hold_strobe_input,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic data_ready_pin,
	output logic cmp_irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	sdfc_pkg::sdfc_ctrl_t ctrl_ff;
	sdfc_pkg::sdfc_ratio_t ratio_ff;
	sdfc_pkg::sdfc_thresh_t thresh_ff;
	logic mclk_s1_ff, mclk_s2_ff, mclk_s3_ff;
	logic mbit_s1_ff, mbit_s2_ff;
	logic [1:0] hs_s1_ff, hs_s2_ff, hs_s3_ff;
	logic smp, hold_rise;
	logic signed [1:0] sinc_x, cmp_x;
	logic signed [sdfc_pkg::SINC_W-1:0] sinc_y;
	logic signed [sdfc_pkg::CMP_W-1:0] cmp_y;
	logic sinc_vld, cmp_vld;
	logic [sdfc_pkg::CMP_W-1:0] cmp_u;
	logic over_hit, under_hit;
	logic signed [sdfc_pkg::INT_W-1:0] acc_ff, data_ff, sinc_ext;
	logic signed [sdfc_pkg::INT_W:0] sum_wide;
	logic signed [sdfc_pkg::INT_W-1:0] sum32;
	logic ovf_evt;
	logic [6:0] icnt_ff;
	logic os_done, hs_done, new_word;
	logic new_ff, over_ff, under_ff, ovf_ff;
	logic rd_data, rd_flags;
	logic [31:0] nxt_rdata;
	logic [31:0] rdata_ff;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------

	// Modulator clock and bit come from outside; two flops before any logic.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mclk_s1_ff <= 1'b0;
			mclk_s2_ff <= 1'b0;
			mclk_s3_ff <= 1'b0;
			mbit_s1_ff <= 1'b0;
			mbit_s2_ff <= 1'b0;
		end else begin
			mclk_s1_ff <= modulator_clock_input;
			mclk_s2_ff <= mclk_s1_ff;
			mclk_s3_ff <= mclk_s2_ff;
			mbit_s1_ff <= modulator_bit_input;
			mbit_s2_ff <= mbit_s1_ff;
		end
	end

	// Both hold strobes are synchronised so the select can change freely.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hs_s1_ff <= 2'h0;
			hs_s2_ff <= 2'h0;
			hs_s3_ff <= 2'h0;
		end else begin
			hs_s1_ff <= hold_strobe_input;
			hs_s2_ff <= hs_s1_ff;
			hs_s3_ff <= hs_s2_ff;
		end
	end

	// The bit is taken with the synchronised rising edge of its clock.
	assign smp = mclk_s2_ff && !mclk_s3_ff;
	assign hold_rise = hs_s2_ff[ctrl_ff.hold_strobe_select] &&
		!hs_s3_ff[ctrl_ff.hold_strobe_select];

	// ----------------------------------------------------------------
	// Filters
	// ----------------------------------------------------------------

	// Main filter sees -1/+1, comparator filter sees 0/1.
	assign sinc_x = mbit_s2_ff ? 2'sh1 : 2'sh3;
	assign cmp_x = mbit_s2_ff ? 2'sh1 : 2'sh0;

	// Runs on every sample while enabled, with no host action.
	sdfc_sinc #(
		.W(sdfc_pkg::SINC_W),
		.RW(8)
	) u_sinc (
		.clk(clk),
		.rst_n(rst_n),
		.run(ctrl_ff.filter_enable_bit),
		.smp(smp),
		.x(sinc_x),
		.order(ctrl_ff.sinc_struct),
		.ratio_m1(ratio_ff.sinc_decimation_ratio),
		.y(sinc_y),
		.y_vld(sinc_vld)
	);

	// Comparator filter; 17 signed bits hold the unsigned peak of 32768.
	sdfc_sinc #(
		.W(sdfc_pkg::CMP_W),
		.RW(5)
	) u_cmp (
		.clk(clk),
		.rst_n(rst_n),
		.run(ctrl_ff.filter_enable_bit),
		.smp(smp),
		.x(cmp_x),
		.order(ctrl_ff.cmp_struct),
		.ratio_m1(ratio_ff.cmp_ratio),
		.y(cmp_y),
		.y_vld(cmp_vld)
	);

	// ----------------------------------------------------------------
	// Threshold comparison
	// ----------------------------------------------------------------

	// Results are never negative, so compare as straight binary.
	assign cmp_u = cmp_y;
	assign over_hit = cmp_vld && (cmp_u > {1'b0, thresh_ff.high});
	assign under_hit = cmp_vld && (cmp_u < {1'b0, thresh_ff.low});

	// Sticky condition flags; a new hit beats a clearing read.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			over_ff <= 1'b0;
			under_ff <= 1'b0;
		end else begin
			if (over_hit) begin
				over_ff <= 1'b1;
			end else if (rd_flags) begin
				over_ff <= 1'b0;
			end
			if (under_hit) begin
				under_ff <= 1'b1;
			end else if (rd_flags) begin
				under_ff <= 1'b0;
			end
		end
	end

	assign cmp_irq = over_ff || under_ff;

	// ----------------------------------------------------------------
	// Integrator
	// ----------------------------------------------------------------

	assign sinc_ext = sdfc_pkg::INT_W'(sinc_y);
	assign sum_wide = {acc_ff[sdfc_pkg::INT_W-1], acc_ff} +
		{sinc_ext[sdfc_pkg::INT_W-1], sinc_ext};
	assign sum32 = sum_wide[sdfc_pkg::INT_W-1:0];
	// Reaching +2^31 or below -2^31 counts as overflow.
	assign ovf_evt = ctrl_ff.integrator_enable_bit && sinc_vld &&
		(sum_wide[sdfc_pkg::INT_W] != sum_wide[sdfc_pkg::INT_W-1]);
	assign os_done = ctrl_ff.integrator_enable_bit && !ctrl_ff.integration_mode_select &&
		sinc_vld && (icnt_ff == ratio_ff.integrator_sum_count);
	assign hs_done = ctrl_ff.integrator_enable_bit && ctrl_ff.integration_mode_select &&
		hold_rise;
	assign new_word = ctrl_ff.integrator_enable_bit ? (os_done || hs_done) : sinc_vld;

	// Accumulator; a sample that meets a hold edge is folded into the stored word.
	always_ff @(posedge clk) begin
		if (!rst_n || !ctrl_ff.integrator_enable_bit || !ctrl_ff.filter_enable_bit) begin
			acc_ff <= '0;
		end else if (os_done || hs_done || ovf_evt) begin
			acc_ff <= '0;
		end else if (sinc_vld) begin
			acc_ff <= sum32;
		end
	end

	// Count of summed words in oversampling mode; restarts with the filter.
	always_ff @(posedge clk) begin
		if (!rst_n || !ctrl_ff.integrator_enable_bit || !ctrl_ff.filter_enable_bit) begin
			icnt_ff <= 7'h00;
		end else if (os_done) begin
			icnt_ff <= 7'h00;
		end else if (sinc_vld && !ctrl_ff.integration_mode_select) begin
			icnt_ff <= icnt_ff + 7'h01;
		end
	end

	// Data word: bypassed sinc word, or the integrator result.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			data_ff <= '0;
		end else if (!ctrl_ff.integrator_enable_bit && sinc_vld) begin
			data_ff <= sinc_ext;
		end else if (os_done) begin
			data_ff <= sum32;
		end else if (hs_done) begin
			data_ff <= sinc_vld ? sum32 : acc_ff;
		end
	end

	// Overflow flag is sticky until the flag register is read.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ovf_ff <= 1'b0;
		end else if (ovf_evt) begin
			ovf_ff <= 1'b1;
		end else if (rd_flags) begin
			ovf_ff <= 1'b0;
		end
	end

	// Data-ready pin: a fresh word beats the read that would clear it.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			new_ff <= 1'b0;
		end else if (new_word) begin
			new_ff <= 1'b1;
		end else if (rd_data) begin
			new_ff <= 1'b0;
		end
	end

	assign data_ready_pin = new_ff;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------

	assign rd_data = rd && (addr == sdfc_pkg::ADDR_DATA);
	assign rd_flags = rd && (addr == sdfc_pkg::ADDR_FLAGS);

	// Configuration writes; writes to other addresses are ignored.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_ff <= sdfc_pkg::CTRL_RST;
			ratio_ff <= sdfc_pkg::RATIO_RST;
			thresh_ff <= sdfc_pkg::THRESH_RST;
		end else if (wr) begin
			if (addr == sdfc_pkg::ADDR_CTRL) begin
				ctrl_ff <= wdata[7:0];
			end else if (addr == sdfc_pkg::ADDR_RATIO) begin
				ratio_ff <= wdata[19:0];
			end else if (addr == sdfc_pkg::ADDR_THRESH) begin
				thresh_ff <= wdata;
			end
		end
	end

	// Read mux; the comparator word has no address at all.
	always_comb begin
		nxt_rdata = 32'h0;
		if (!rd) begin
			nxt_rdata = 32'h0;
		end else if (addr == sdfc_pkg::ADDR_CTRL) begin
			nxt_rdata = {24'h0, ctrl_ff};
		end else if (addr == sdfc_pkg::ADDR_RATIO) begin
			nxt_rdata = {12'h0, ratio_ff};
		end else if (addr == sdfc_pkg::ADDR_THRESH) begin
			nxt_rdata = thresh_ff;
		end else if (addr == sdfc_pkg::ADDR_DATA) begin
			nxt_rdata = data_ff;
		end else if (addr == sdfc_pkg::ADDR_FLAGS) begin
			nxt_rdata[sdfc_pkg::FLAG_NEW] = new_ff;
			nxt_rdata[sdfc_pkg::FLAG_OVER] = over_ff;
			nxt_rdata[sdfc_pkg::FLAG_UNDER] = under_ff;
			nxt_rdata[sdfc_pkg::FLAG_OVF] = ovf_ff;
		end
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_ff <= 32'h0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign rdata = rdata_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_data_read;
		rd && (addr == sdfc_pkg::ADDR_DATA) && !new_word;
	endsequence

	sequence s_hold_capture;
		hs_done && !sinc_vld;
	endsequence

	a_ack_on_word: assert property (new_word |=> data_ready_pin)
		else $error("data-ready pin not raised after new word");
	a_ack_dropped: assert property (s_data_read |=> !data_ready_pin)
		else $error("data-ready pin still high after data read");
	a_over_detect: assert property (over_hit |=> over_ff && cmp_irq)
		else $error("over-value hit not recorded");
	a_under_detect: assert property (under_hit |=> under_ff && cmp_irq)
		else $error("under-value hit not recorded");
	a_flags_readback: assert property (rd_flags && over_ff && !over_hit
		|=> rdata[sdfc_pkg::FLAG_OVER] && !over_ff)
		else $error("over-value flag not reported or not cleared");
	a_unmapped_zero: assert property (rd && (addr > sdfc_pkg::ADDR_FLAGS)
		|=> rdata == 32'h0)
		else $error("unmapped read returned nonzero data");
	a_int_off_clear: assert property (!ctrl_ff.integrator_enable_bit
		|=> acc_ff == 0)
		else $error("disabled integrator not cleared");
	a_int_bypass: assert property (!ctrl_ff.integrator_enable_bit && sinc_vld
		|=> data_ff == $past(sinc_ext))
		else $error("bypassed word not passed to data register");
	a_hold_store: assert property (s_hold_capture
		|=> data_ff == $past(acc_ff) && acc_ff == 0 && data_ready_pin)
		else $error("hold edge did not store and clear");
	a_os_deliver: assert property (os_done
		|=> data_ff == $past(sum32) && acc_ff == 0 && icnt_ff == 0)
		else $error("oversampled sum not delivered");
	a_ovf_flag: assert property (ovf_evt |=> ovf_ff && acc_ff == 0)
		else $error("overflow not flagged or accumulator kept");
	a_rd_one_cycle: assert property (!rd |=> rdata == 32'h0)
		else $error("read data present without a read strobe");

endmodule : sdfc_channel

/* hdl/sdfc_pkg.sv */
// Shared constants and types for the sigma-delta filter channel.
package sdfc_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int SINC_W = 26;
	localparam int CMP_W = 17;
	localparam int INT_W = 32;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_RATIO = 8'h04;
	localparam logic [7:0] ADDR_THRESH = 8'h08;
	localparam logic [7:0] ADDR_DATA = 8'h0c;
	localparam logic [7:0] ADDR_FLAGS = 8'h10;

	// ----------------------------------------------------------------
	// Flag register bit positions
	// ----------------------------------------------------------------
	localparam int FLAG_NEW = 0;
	localparam int FLAG_OVER = 1;
	localparam int FLAG_UNDER = 2;
	localparam int FLAG_OVF = 3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		sdfc_sinc1 = 2'b00,
		sdfc_sinc2 = 2'b01,
		sdfc_sinc3 = 2'b10,
		sdfc_fast = 2'b11
	} sdfc_struct_t;

	typedef struct packed {
		logic hold_strobe_select;
		logic integration_mode_select;
		logic integrator_enable_bit;
		sdfc_struct_t cmp_struct;
		sdfc_struct_t sinc_struct;
		logic filter_enable_bit;
	} sdfc_ctrl_t;

	// Each ratio field holds the ratio minus one.
	typedef struct packed {
		logic [6:0] integrator_sum_count;
		logic [4:0] cmp_ratio;
		logic [7:0] sinc_decimation_ratio;
	} sdfc_ratio_t;

	typedef struct packed {
		logic [15:0] high;
		logic [15:0] low;
	} sdfc_thresh_t;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [19:0] RATIO_RST = 20'h00000;
	localparam logic [31:0] THRESH_RST = 32'hffff_0000;

endpackage : sdfc_pkg

/* hdl/sdfc_sinc.sv */
// Generic integrate, decimate and differentiate sinc filter of order one to three.
module sdfc_sinc #(
	parameter int W = 26,
	parameter int RW = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic smp,
	input wire logic signed [1:0] x,
	input wire sdfc_pkg::sdfc_struct_t order,
	input wire logic [RW-1:0] ratio_m1,
	output logic signed [W-1:0] y,
	output logic y_vld
);

	logic signed [W-1:0] i1_ff, i2_ff, i3_ff;
	logic signed [W-1:0] nxt_i1, nxt_i2, nxt_i3;
	logic signed [W-1:0] d1_ff, d2_ff, d3_ff;
	logic signed [W-1:0] pick, c1, c2, c3, nxt_y;
	logic [RW-1:0] cnt_ff;
	logic dec;

	// One output per ratio count of input samples.
	assign dec = smp && (cnt_ff == ratio_m1);

	// Integrators and comb differences; wrap-around arithmetic is exact modulo 2^W.
	always_comb begin
		nxt_i1 = i1_ff + W'(x);
		nxt_i2 = i2_ff + nxt_i1;
		nxt_i3 = i3_ff + nxt_i2;
		case (order)
			sdfc_pkg::sdfc_sinc1: pick = nxt_i1;
			sdfc_pkg::sdfc_sinc3: pick = nxt_i3;
			default: pick = nxt_i2;
		endcase
		c1 = pick - d1_ff;
		c2 = c1 - d2_ff;
		c3 = c2 - d3_ff;
		case (order)
			sdfc_pkg::sdfc_sinc1: nxt_y = c1;
			sdfc_pkg::sdfc_sinc2: nxt_y = c2;
			sdfc_pkg::sdfc_sinc3: nxt_y = c3;
			default: nxt_y = c2 <<< 1; // Fast structure doubles the second-order peak.
		endcase
	end

	// Integrator state runs at the input sample rate.
	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			i1_ff <= '0;
			i2_ff <= '0;
			i3_ff <= '0;
			cnt_ff <= '0;
		end else if (smp) begin
			i1_ff <= nxt_i1;
			i2_ff <= nxt_i2;
			i3_ff <= nxt_i3;
			cnt_ff <= dec ? '0 : cnt_ff + 1'b1;
		end
	end

	// Comb delays and the output word update only at decimation.
	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			d1_ff <= '0;
			d2_ff <= '0;
			d3_ff <= '0;
			y <= '0;
			y_vld <= 1'b0;
		end else begin
			y_vld <= dec;
			if (dec) begin
				d1_ff <= pick;
				d2_ff <= c1;
				d3_ff <= c2;
				y <= nxt_y;
			end
		end
	end

endmodule : sdfc_sinc
